// file: tw_pkg.sv
// constants shared by the two ends of the two-wire link
// assumes a 20 MHz core clock on both ends
package tw_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_MHZ = 20;
  localparam int HALF_BIT_NS = 2500;
  localparam int HALF_BIT_CYC = (HALF_BIT_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0] HALF_CNT_MAX = 8'(HALF_BIT_CYC - 1);
  localparam int START_HOLD_NS = 2500;
  localparam int START_HOLD_CYC = (START_HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0] START_CNT_MAX = 8'(START_HOLD_CYC - 1);

  // ****************************************
  // device software port
  // ****************************************
  localparam logic [2:0] DEV_CTRL = 3'h0;
  localparam logic [2:0] DEV_STAT = 3'h1;
  localparam logic [2:0] DEV_DATA = 3'h2;
  localparam logic [2:0] DEV_OWN = 3'h3;
  localparam logic [2:0] DEV_IRQ = 3'h4;
  localparam logic [2:0] DEV_MASK = 3'h5;
  // control_word bit positions
  localparam int CTL_DONE = 7;
  localparam int CTL_ACK = 6;
  localparam int CTL_STA = 5;
  localparam int CTL_STO = 4;
  localparam int CTL_WCOL = 3;
  localparam int CTL_EN = 2;
  // state_code_word layout
  localparam int CODE_LSB = 3;
  localparam logic [7:0] CODE_SLA_R = 8'hA8;
  localparam logic [7:0] CODE_ARB_SLA_R = 8'hB0;
  localparam logic [7:0] CODE_DATA_ACK = 8'hB8;
  localparam logic [7:0] CODE_DATA_NACK = 8'hC0;
  localparam logic [7:0] CODE_LAST_ACK = 8'hC8;
  localparam logic [7:0] CODE_NO_INFO = 8'hF8;
  localparam logic [7:0] CODE_BUS_ERR = 8'h00;
  localparam logic [6:0] GENERAL_CALL_ADDRESS = 7'h00;
  // reset values
  localparam logic [7:0] OWN_ADDR_RST = 8'h00;
  // interrupt status bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_BERR = 1;

  // ****************************************
  // host software port
  // ****************************************
  localparam logic [2:0] HOST_CMD = 3'h0;
  localparam logic [2:0] HOST_TXD = 3'h1;
  localparam logic [2:0] HOST_RXD = 3'h2;
  localparam logic [2:0] HOST_STAT = 3'h3;
  localparam logic [2:0] HOST_IRQ = 3'h4;
  localparam logic [2:0] HOST_MASK = 3'h5;
  localparam logic [2:0] OP_START = 3'h1;
  localparam logic [2:0] OP_STOP = 3'h2;
  localparam logic [2:0] OP_WRITE = 3'h3;
  localparam logic [2:0] OP_READ = 3'h4;
  localparam int CMD_NACK = 3;
  localparam int HS_BUSY = 0;
  localparam int HS_NACK = 1;

endpackage

// file: two_wire_if.sv
// wired-and two-wire bus joining the device end and the host end
// assumes each end drives low only through its output enable
`timescale 1ns/10ps
interface two_wire_if;
  logic dev_scl_o;
  logic dev_scl_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic scl;
  logic sda;

  // open-drain resolution with pull-up
  assign scl = !((dev_scl_oe && !dev_scl_o) || (host_scl_oe && !host_scl_o));
  assign sda = !((dev_sda_oe && !dev_sda_o) || (host_sda_oe && !host_sda_o));

  modport dev (input scl, input sda, output dev_scl_o, output dev_scl_oe,
               output dev_sda_o, output dev_sda_oe);
  modport host (input scl, input sda, output host_scl_o, output host_scl_oe,
                output host_sda_o, output host_sda_oe);
endinterface // two_wire_if

// file: two_wire_slave_tx.sv
// slave transmitter end of the two-wire link with its software port
// assumes bus pins arrive asynchronously and a master clocks the bus
// Behaviour
// - own address read acked: code A8, load byte
// - lost arbitration then read-addressed: code B0
// - byte acked: code B8, send next byte
// - byte not acked: code C0, not addressed
// - last byte acked anyway: code C8, not addressed
// - code F8 whenever job-done flag clear
// - misplaced start or stop gives code 00
// - bus error sets job-done flag
// - software recovers with stop and flag write
// - recovery: not addressed, stop cleared, lines released
// - repeated start changes direction, master keeps bus
// - software keeps combined transfers atomic
// - own address upper seven, lsb general call
// - flag set holds clock low; the code holds it only while a byte is owed in S_WAIT_LOAD
// - code in upper five bits, prescaler low
//
// Local design decisions: the placing of the registers and strobed register access.
`timescale 1ns/10ps
module two_wire_slave_tx (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  output logic irq_o,
  two_wire_if.dev bus
);

  // ****************************************
  // declarations
  // ****************************************
  typedef enum logic [3:0] {
    S_IDLE, S_START, S_ADDR, S_ADDR_ACK, S_WAIT_LOAD, S_TX, S_TX_ACK, S_BERR
  } dev_state_t;

  dev_state_t state, next_state;
  logic [1:0] scl_sync, sda_sync;
  logic scl_d, sda_d;
  logic done_flag, ack_enable_bit, start_request_bit, stop_request_bit;
  logic wcol, enable;
  logic [4:0] code_q, set_code;
  logic [7:0] data_buffer, own_address_word;
  logic [1:0] presc, irq_stat, irq_mask;
  logic [7:0] shreg, next_shreg;
  logic [3:0] bit_cnt, next_cnt;
  logic [7:0] hold_cnt, next_hold;
  logic sda_drv, next_sda_drv, owns, next_owns, lost, next_lost;
  logic last, next_last, ack_rx, next_ack_rx, gc_hit, next_gc;
  logic bus_free, set_done, berr;

  // ****************************************
  // pin synchronisers and bus conditions
  // ****************************************
  wire scl_s = scl_sync[1];
  wire sda_s = sda_sync[1];
  wire scl_rise = scl_s && !scl_d;
  wire scl_fall = !scl_s && scl_d;
  wire start_cond = scl_s && scl_d && sda_d && !sda_s;
  wire stop_cond = scl_s && scl_d && !sda_d && sda_s;

  // two flops per pin, third stage for edges
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], bus.scl};
      sda_sync <= {sda_sync[0], bus.sda};
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  // free after stop, busy after start
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      bus_free <= 1'b1;
    end else if (start_cond) begin
      bus_free <= 1'b0;
    end else if (stop_cond) begin
      bus_free <= 1'b1;
    end
  end

  // ****************************************
  // software port decode
  // ****************************************
  wire ctl_wr = wr_i && (addr_i == tw_pkg::DEV_CTRL);
  wire data_wr = wr_i && (addr_i == tw_pkg::DEV_DATA);
  wire resume = ctl_wr && wdata_i[tw_pkg::CTL_DONE];
  wire recover = resume && wdata_i[tw_pkg::CTL_STO];
  wire [4:0] code_shown = done_flag ? code_q :
                          tw_pkg::CODE_NO_INFO[7:tw_pkg::CODE_LSB];
  wire [7:0] ctrl_rd = {done_flag, ack_enable_bit, start_request_bit, stop_request_bit,
                        wcol, enable, 2'h0};
  wire [7:0] stat_rd = {code_shown, 1'b0, presc};
  wire [7:0] rd_mux = (addr_i == tw_pkg::DEV_CTRL) ? ctrl_rd :
                      (addr_i == tw_pkg::DEV_STAT) ? stat_rd :
                      (addr_i == tw_pkg::DEV_DATA) ? data_buffer :
                      (addr_i == tw_pkg::DEV_OWN) ? own_address_word :
                      (addr_i == tw_pkg::DEV_IRQ) ? {6'h00, irq_stat} :
                      (addr_i == tw_pkg::DEV_MASK) ? {6'h00, irq_mask} : 8'h00;

  // address recognition
  wire match_rd = ack_enable_bit && shreg[0] &&
                  (shreg[7:1] == own_address_word[7:1]);
  wire match_gc = ack_enable_bit && own_address_word[0] &&
                  (shreg[7:1] == tw_pkg::GENERAL_CALL_ADDRESS);
  wire in_frame = ((state == S_ADDR) && (bit_cnt != 4'h0)) || (state == S_ADDR_ACK) ||
                  (state == S_TX) || (state == S_TX_ACK);
  wire frame_err = (start_cond || stop_cond) && in_frame;

  // ****************************************
  // transfer state machine
  // ****************************************
  always_comb begin
    next_state = state;
    next_shreg = shreg;
    next_cnt = bit_cnt;
    next_hold = hold_cnt;
    next_sda_drv = sda_drv;
    next_owns = owns;
    next_lost = lost;
    next_last = last;
    next_ack_rx = ack_rx;
    next_gc = gc_hit;
    set_done = 1'b0;
    set_code = code_q;
    berr = 1'b0;
    if (!enable) begin
      next_state = S_IDLE;
      next_sda_drv = 1'b1;
      next_owns = 1'b0;
    end else if (recover) begin
      // silent return, no stop driven
      next_state = S_IDLE;
      next_sda_drv = 1'b1;
      next_owns = 1'b0;
    end else if (frame_err) begin
      next_state = S_BERR;
      next_sda_drv = 1'b1;
      next_owns = 1'b0;
      set_done = 1'b1;
      set_code = tw_pkg::CODE_BUS_ERR[7:tw_pkg::CODE_LSB];
      berr = 1'b1;
    end else begin
      unique case (state)
        S_IDLE: begin
          if (start_cond) begin
            next_state = S_ADDR;
            next_cnt = 4'h0;
            next_owns = 1'b0;
            next_lost = 1'b0;
          end else if (start_request_bit && bus_free && !done_flag) begin
            next_state = S_START;
            next_hold = 8'h00;
            next_sda_drv = 1'b0;
          end
        end
        S_START: begin
          next_hold = hold_cnt + 8'h01;
          if (hold_cnt == tw_pkg::START_CNT_MAX) begin
            next_state = S_ADDR;
            next_cnt = 4'h0;
            next_owns = 1'b1;
            next_lost = 1'b0;
            next_shreg = data_buffer;
          end
        end
        S_ADDR: begin
          if (stop_cond) begin
            next_state = S_IDLE;
          end else if (start_cond) begin
            next_cnt = 4'h0;
          end else if (scl_rise) begin
            next_shreg = {shreg[6:0], sda_s};
            next_cnt = bit_cnt + 4'h1;
            if (owns && sda_drv && !sda_s) begin
              next_owns = 1'b0;
              next_lost = 1'b1;
            end
          end else if (scl_fall) begin
            if (bit_cnt != 4'h8) begin
              next_sda_drv = owns ? shreg[7] : 1'b1;
            end else if (owns) begin
              next_state = S_IDLE;
              next_sda_drv = 1'b1;
              next_owns = 1'b0;
            end else if (match_rd || match_gc) begin
              next_state = S_ADDR_ACK;
              next_sda_drv = 1'b0;
              next_gc = !match_rd;
            end else begin
              next_state = S_IDLE;
              next_sda_drv = 1'b1;
            end
          end
        end
        S_ADDR_ACK: begin
          if (scl_fall) begin
            next_sda_drv = 1'b1;
            if (gc_hit) begin
              next_state = S_IDLE;
            end else begin
              next_state = S_WAIT_LOAD;
              set_done = 1'b1;
              set_code = lost ? tw_pkg::CODE_ARB_SLA_R[7:tw_pkg::CODE_LSB] :
                                tw_pkg::CODE_SLA_R[7:tw_pkg::CODE_LSB];
            end
          end
        end
        S_WAIT_LOAD: begin
          if (resume) begin
            next_state = S_TX;
            next_shreg = data_buffer;
            next_sda_drv = data_buffer[7];
            next_cnt = 4'h0;
            next_last = !wdata_i[tw_pkg::CTL_ACK];
          end
        end
        S_TX: begin
          if (scl_rise) begin
            next_shreg = {shreg[6:0], sda_s};
            next_cnt = bit_cnt + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt == 4'h8) begin
              next_state = S_TX_ACK;
              next_sda_drv = 1'b1;
            end else begin
              next_sda_drv = shreg[7];
            end
          end
        end
        S_TX_ACK: begin
          if (scl_rise) begin
            next_ack_rx = sda_s;
          end else if (scl_fall) begin
            set_done = 1'b1;
            if (ack_rx) begin
              next_state = S_IDLE;
              set_code = tw_pkg::CODE_DATA_NACK[7:tw_pkg::CODE_LSB];
            end else if (last) begin
              next_state = S_IDLE;
              set_code = tw_pkg::CODE_LAST_ACK[7:tw_pkg::CODE_LSB];
            end else begin
              next_state = S_WAIT_LOAD;
              set_code = tw_pkg::CODE_DATA_ACK[7:tw_pkg::CODE_LSB];
            end
          end
        end
        S_BERR: begin
          next_sda_drv = 1'b1;
        end
      endcase
    end
  end

  // state and shifter
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state <= S_IDLE;
      shreg <= 8'h00;
      bit_cnt <= 4'h0;
      hold_cnt <= 8'h00;
      sda_drv <= 1'b1;
      owns <= 1'b0;
      lost <= 1'b0;
      last <= 1'b0;
      ack_rx <= 1'b1;
      gc_hit <= 1'b0;
    end else begin
      state <= next_state;
      shreg <= next_shreg;
      bit_cnt <= next_cnt;
      hold_cnt <= next_hold;
      sda_drv <= next_sda_drv;
      owns <= next_owns;
      lost <= next_lost;
      last <= next_last;
      ack_rx <= next_ack_rx;
      gc_hit <= next_gc;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  // flag: set wins over the write-one clear, code only moves on set
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      done_flag <= 1'b0;
      code_q <= tw_pkg::CODE_NO_INFO[7:tw_pkg::CODE_LSB];
    end else begin
      done_flag <= set_done || (done_flag && !resume);
      code_q <= set_done ? set_code : code_q;
    end
  end

  // control bits, stop bit dropped by recovery
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ack_enable_bit <= 1'b0;
      start_request_bit <= 1'b0;
      stop_request_bit <= 1'b0;
      enable <= 1'b0;
    end else if (ctl_wr) begin
      ack_enable_bit <= wdata_i[tw_pkg::CTL_ACK];
      start_request_bit <= wdata_i[tw_pkg::CTL_STA];
      stop_request_bit <= wdata_i[tw_pkg::CTL_STO] && !recover;
      enable <= wdata_i[tw_pkg::CTL_EN];
    end
  end

  // data, own address, prescaler, write collision
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      data_buffer <= 8'h00;
      own_address_word <= tw_pkg::OWN_ADDR_RST;
      presc <= 2'h0;
      wcol <= 1'b0;
    end else begin
      if (data_wr && done_flag) begin
        data_buffer <= wdata_i;
      end
      if (data_wr) begin
        wcol <= !done_flag;
      end
      if (wr_i && (addr_i == tw_pkg::DEV_OWN)) begin
        own_address_word <= wdata_i;
      end
      if (wr_i && (addr_i == tw_pkg::DEV_STAT)) begin
        presc <= wdata_i[1:0];
      end
    end
  end

  // sticky events, write one to clear, set wins
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      irq_stat <= 2'h0;
      irq_mask <= 2'h0;
      rdata_o <= 8'h00;
    end else begin
      irq_stat[tw_pkg::IRQ_DONE] <= set_done ||
        (irq_stat[tw_pkg::IRQ_DONE] && !(wr_i && (addr_i == tw_pkg::DEV_IRQ) &&
         wdata_i[tw_pkg::IRQ_DONE]));
      irq_stat[tw_pkg::IRQ_BERR] <= berr ||
        (irq_stat[tw_pkg::IRQ_BERR] && !(wr_i && (addr_i == tw_pkg::DEV_IRQ) &&
         wdata_i[tw_pkg::IRQ_BERR]));
      if (wr_i && (addr_i == tw_pkg::DEV_MASK)) begin
        irq_mask <= wdata_i[1:0];
      end
      rdata_o <= rd_i ? rd_mux : 8'h00;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // clock held low while software owes a byte
  assign bus.dev_scl_oe = done_flag && (state == S_WAIT_LOAD);
  assign bus.dev_scl_o = 1'b0;
  assign bus.dev_sda_oe = !sda_drv;
  assign bus.dev_sda_o = 1'b0;
  assign irq_o = |(irq_stat & irq_mask);

endmodule // two_wire_slave_tx

// file: two_wire_master_host.sv
// bus master end of the two-wire link, driven by start/stop/byte commands
// assumes the far end may stretch the clock low at any time
`timescale 1ns/10ps
module two_wire_master_host (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  output logic irq_o,
  two_wire_if.host bus
);

  // ****************************************
  // declarations
  // ****************************************
  typedef enum logic [2:0] {H_IDLE, H_LOW, H_RISE, H_HIGH, H_TAIL} host_state_t;
  typedef enum logic [1:0] {K_START, K_STOP, K_BYTE} kind_t;

  host_state_t state;
  kind_t kind;
  logic [1:0] scl_sync, sda_sync;
  logic [7:0] cnt, tx_data, rx_data;
  logic [8:0] shout, shin;
  logic [3:0] nbit;
  logic sda_drv, scl_drv, nack_rx, irq_stat, irq_mask, done_ev;

  wire scl_s = scl_sync[1];
  wire sda_s = sda_sync[1];
  wire half_done = (cnt == tw_pkg::HALF_CNT_MAX);
  wire counting = (state == H_LOW) || (state == H_HIGH) || (state == H_TAIL);
  wire cmd_wr = wr_i && (addr_i == tw_pkg::HOST_CMD) && (state == H_IDLE);
  wire [2:0] op = wdata_i[2:0];
  wire [8:0] load_bits = (op == tw_pkg::OP_WRITE) ? {tx_data, 1'b1} :
                         {8'hFF, wdata_i[tw_pkg::CMD_NACK]};
  wire op_ok = (op == tw_pkg::OP_START) || (op == tw_pkg::OP_STOP) ||
               (op == tw_pkg::OP_WRITE) || (op == tw_pkg::OP_READ);
  wire [7:0] rd_mux = (addr_i == tw_pkg::HOST_TXD) ? tx_data :
                      (addr_i == tw_pkg::HOST_RXD) ? rx_data :
                      (addr_i == tw_pkg::HOST_STAT) ? {6'h00, nack_rx, state != H_IDLE} :
                      (addr_i == tw_pkg::HOST_IRQ) ? {7'h00, irq_stat} :
                      (addr_i == tw_pkg::HOST_MASK) ? {7'h00, irq_mask} : 8'h00;

  // ****************************************
  // pin synchronisers
  // ****************************************
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
    end else begin
      scl_sync <= {scl_sync[0], bus.scl};
      sda_sync <= {sda_sync[0], bus.sda};
    end
  end

  // ****************************************
  // bit engine
  // ****************************************
  // low half, release, wait out stretching, high half, act
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state <= H_IDLE;
      kind <= K_START;
      cnt <= 8'h00;
      shout <= 9'h1FF;
      shin <= 9'h000;
      nbit <= 4'h0;
      sda_drv <= 1'b1;
      scl_drv <= 1'b1;
      done_ev <= 1'b0;
    end else begin
      done_ev <= 1'b0;
      // restart at each half so no phase inherits a stale count
      cnt <= (counting && !half_done) ? cnt + 8'h01 : 8'h00;
      unique case (state)
        H_IDLE: begin
          if (cmd_wr && op_ok) begin
            state <= H_LOW;
            nbit <= 4'h0;
            kind <= (op == tw_pkg::OP_START) ? K_START :
                    (op == tw_pkg::OP_STOP) ? K_STOP : K_BYTE;
            // repeated start releases data first, then clock
            sda_drv <= (op == tw_pkg::OP_STOP) ? 1'b0 :
                       (op == tw_pkg::OP_START) ? 1'b1 : load_bits[8];
            shout <= {load_bits[7:0], 1'b1};
          end
        end
        H_LOW: begin
          if (half_done) begin
            state <= H_RISE;
            scl_drv <= 1'b1;
          end
        end
        H_RISE: begin
          if (scl_s) begin
            state <= H_HIGH;
          end
        end
        H_HIGH: begin
          if (half_done) begin
            unique case (kind)
              K_START: begin
                sda_drv <= 1'b0;
                state <= H_TAIL;
              end
              K_STOP: begin
                sda_drv <= 1'b1;
                state <= H_IDLE;
                done_ev <= 1'b1;
              end
              K_BYTE: begin
                shin <= {shin[7:0], sda_s};
                scl_drv <= 1'b0;
                nbit <= nbit + 4'h1;
                if (nbit == 4'h8) begin
                  state <= H_IDLE;
                  done_ev <= 1'b1;
                end else begin
                  state <= H_TAIL;
                end
              end
              default: state <= H_IDLE;
            endcase
          end
        end
        H_TAIL: begin
          // data changes only while the clock is low
          if (kind == K_START && half_done) begin
            scl_drv <= 1'b0;
            state <= H_IDLE;
            done_ev <= 1'b1;
          end else if (kind == K_BYTE) begin
            sda_drv <= shout[8];
            shout <= {shout[7:0], 1'b1};
            state <= H_LOW;
          end
        end
      endcase
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      tx_data <= 8'h00;
      rx_data <= 8'h00;
      nack_rx <= 1'b0;
      irq_stat <= 1'b0;
      irq_mask <= 1'b0;
      rdata_o <= 8'h00;
    end else begin
      if (wr_i && (addr_i == tw_pkg::HOST_TXD)) begin
        tx_data <= wdata_i;
      end
      if (done_ev && kind == K_BYTE) begin
        rx_data <= shin[8:1];
        nack_rx <= shin[0];
      end
      irq_stat <= done_ev || (irq_stat && !(wr_i && (addr_i == tw_pkg::HOST_IRQ) && wdata_i[0]));
      if (wr_i && (addr_i == tw_pkg::HOST_MASK)) begin
        irq_mask <= wdata_i[0];
      end
      rdata_o <= rd_i ? rd_mux : 8'h00;
    end
  end

  assign bus.host_scl_oe = !scl_drv;
  assign bus.host_scl_o = 1'b0;
  assign bus.host_sda_oe = !sda_drv;
  assign bus.host_sda_o = 1'b0;
  assign irq_o = irq_stat && irq_mask;

endmodule // two_wire_master_host

// file: two_wire_properties.sv
// link checks on the per-end output enables and the resolved two-wire interface signals
// assumes both ends run on the one core clock
`timescale 1ns/10ps
module two_wire_properties (
  input logic core_clk_i,
  input logic rst_i,
  input logic host_rst_i,
  input logic dev_scl_oe,
  input logic dev_sda_oe,
  input logic host_scl_oe,
  input logic host_sda_oe,
  input logic scl,
  input logic sda
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // ****
  // link assertions and covers
  // ****
  dev_rst_idle_a: assert property (disable iff (1'b0) rst_i |=> !dev_scl_oe && !dev_sda_oe)
    else $error("device drives after reset");
  host_rst_idle_a: assert property (disable iff (1'b0)
    host_rst_i |=> !host_scl_oe && !host_sda_oe) else $error("host drives after reset");
  stretch_low_a: assert property ($rose(dev_scl_oe) |-> !$past(scl))
    else $error("clock pulled while high");
  sda_launch_a: assert property ($rose(dev_sda_oe) |-> !scl && !$past(scl))
    else $error("data moved while clock high");
  no_clash_a: assert property (scl |-> !(dev_sda_oe && host_sda_oe))
    else $error("both ends drive data");
  host_low_a: assert property (disable iff (rst_i || host_rst_i)
    $rose(host_scl_oe) |=> host_scl_oe [*8]) else $error("host low phase short");
  dev_sda_rel_a: assert property ($fell(dev_sda_oe) |-> !scl)
    else $error("data released while clock high");
  stretch_free_a: assert property (dev_scl_oe |-> !dev_sda_oe)
    else $error("data held while stretching");
  stretch_c: cover property ($rose(dev_scl_oe));
  start_c: cover property (scl && $fell(sda));
  dev_data_c: cover property (scl && dev_sda_oe);
endmodule // two_wire_properties

// file: tb_two_wire_slave_tx.sv
// bench: device end and host end joined over one link
// assumes tw_pkg and two_wire_if are compiled first
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin mismatches++; \
  $display("[FAIL] %s exp %h got %h", nm, ex, gt); end end
module tb_two_wire_slave_tx;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic host_rst = 1'b1;
  logic [2:0] ad [2] = '{3'h0, 3'h0};
  logic [7:0] wd [2] = '{8'h00, 8'h00};
  logic we [2] = '{1'b0, 1'b0};
  logic re [2] = '{1'b0, 1'b0};
  logic [7:0] q [2];
  logic irq [2];
  int mismatches = 0;
  int n_tests = 0;
  two_wire_if tw ();
  // ****
  // both ends and the link checker
  // ****
  two_wire_slave_tx two_wire_slave_tx_inst (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .addr_i(ad[0]), .wdata_i(wd[0]), .wr_i(we[0]), .rd_i(re[0]), .rdata_o(q[0]),
    .irq_o(irq[0]), .bus(tw));
  two_wire_master_host two_wire_master_host_inst (.core_clk_i(core_clk_i), .rst_i(host_rst),
    .addr_i(ad[1]), .wdata_i(wd[1]), .wr_i(we[1]), .rd_i(re[1]), .rdata_o(q[1]),
    .irq_o(irq[1]), .bus(tw));
  two_wire_properties two_wire_properties_inst (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .host_rst_i(host_rst), .dev_scl_oe(tw.dev_scl_oe), .dev_sda_oe(tw.dev_sda_oe),
    .host_scl_oe(tw.host_scl_oe), .host_sda_oe(tw.host_sda_oe), .scl(tw.scl), .sda(tw.sda));
  // clock
  always #25 core_clk_i = ~core_clk_i;
  // one-cycle write, or read judged in the next cycle
  task automatic acc(input int s, input bit w, input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    ad[s] <= a;
    wd[s] <= d;
    we[s] <= w;
    re[s] <= !w;
    @(posedge core_clk_i);
    we[s] <= 1'b0;
    re[s] <= 1'b0;
    #1;
    if (!w) `CHK("rdata", d, q[s])
  endtask
  // bounded wait for an interrupt, then clear it
  task automatic wait_irq(input int s);
    for (int k = 0; k < 5000 && irq[s] !== 1'b1; k++) @(posedge core_clk_i);
    `CHK("irq", 1'b1, irq[s])
    acc(s, 1, 3'h4, 8'h03);
  endtask
  // host command run to completion
  task automatic hop(input logic [7:0] c);
    acc(1, 1, 3'h0, c);
    wait_irq(1);
  endtask
  // start, own address with read bit
  task automatic sel_rd();
    hop(8'h01);
    acc(1, 1, 3'h1, 8'h55);
    hop(8'h03);
    wait_irq(0);
    acc(0, 0, 3'h1, 8'hA8);
  endtask
  // load a byte, free the flag, host reads it, device reports
  task automatic xfer(input logic [7:0] d, input logic [7:0] c, input logic [7:0] h);
    acc(0, 1, 3'h2, d);
    acc(0, 1, 3'h0, c);
    hop(h);
    acc(1, 0, 3'h2, d);
    wait_irq(0);
  endtask
  // reset values, then setup of both ends
  task automatic t_reset();
    acc(0, 0, 3'h1, 8'hF8);
    acc(0, 1, 3'h3, 8'h54);
    acc(0, 1, 3'h5, 8'h01);
    acc(1, 1, 3'h5, 8'h01);
    acc(0, 1, 3'h0, 8'h44);
  endtask
  // acked byte, then a last byte refused
  task automatic t_nack();
    sel_rd();
    acc(0, 0, 3'h1, 8'hA8);
    xfer(8'hA5, 8'hC4, 8'h04);
    acc(0, 0, 3'h1, 8'hB8);
    xfer(8'h3C, 8'h84, 8'h0C);
    acc(0, 0, 3'h1, 8'hC0);
    acc(0, 1, 3'h0, 8'hC4);
    acc(0, 0, 3'h1, 8'hF8);
    hop(8'h02);
  endtask
  // write address, repeated start into a read, last byte acked
  task automatic t_last();
    hop(8'h01);
    acc(1, 1, 3'h1, 8'h54);
    hop(8'h03);
    sel_rd();
    xfer(8'h0F, 8'h84, 8'h04);
    acc(0, 0, 3'h1, 8'hC8);
    acc(0, 1, 3'h0, 8'hC4);
    hop(8'h0C);
    acc(1, 0, 3'h2, 8'hFF);
    hop(8'h02);
  endtask
  // host restarts in mid address byte, software recovers
  task automatic t_err();
    acc(0, 1, 3'h5, 8'h00);
    hop(8'h01);
    acc(1, 1, 3'h0, 8'h03);
    repeat (250) @(posedge core_clk_i);
    host_rst <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    host_rst <= 1'b0;
    acc(1, 1, 3'h5, 8'h01);
    hop(8'h01);
    `CHK("irq", 1'b0, irq[0])
    acc(0, 0, 3'h1, 8'h00);
    acc(0, 0, 3'h0, 8'hC4);
    acc(0, 1, 3'h5, 8'h02);
    `CHK("irq", 1'b1, irq[0])
    acc(0, 1, 3'h0, 8'hD4);
    acc(0, 0, 3'h0, 8'h44);
    `CHK("oe", 2'b00, {tw.dev_scl_oe, tw.dev_sda_oe})
    acc(0, 1, 3'h4, 8'h03);
    `CHK("irq", 1'b0, irq[0])
    hop(8'h02);
  endtask
  // verdict and end of run
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // reset, then the scenarios
  initial begin
    repeat (10) @(posedge core_clk_i);
    rst_i <= 1'b0;
    host_rst <= 1'b0;
    t_reset();
    t_nack();
    t_last();
    t_err();
    close_out();
  end
  // watchdog
  initial begin
    #3000000;
    mismatches++;
    close_out();
  end
endmodule // tb_two_wire_slave_tx
